// [design/dcf_pkg.sv]
// constants, control bundle and init states for the dual-clock fifo
// flag and mailbox block; assumes two free-running port clocks.
package dcf_pkg;

    localparam int DCF_WIDTH = 36;
    localparam int DCF_DEPTH = 64;
    localparam int DCF_AW    = 6;
    localparam int DCF_PW    = 7;
    localparam int DCF_OW    = 5;

    // word count that means "every location holds data"
    localparam logic [DCF_PW-1:0] DCF_FULL_COUNT = 7'h40;

    // offset presets: four selected by the two threshold code straps, DCF_OFS_RST loaded by reset
    localparam logic [DCF_OW-1:0] DCF_OFS_HH = 5'h10;
    localparam logic [DCF_OW-1:0] DCF_OFS_HL = 5'h0c;
    localparam logic [DCF_OW-1:0] DCF_OFS_LH = 5'h08;
    localparam logic [DCF_OW-1:0] DCF_OFS_LL = 5'h04;
    localparam logic [DCF_OW-1:0] DCF_OFS_RST = 5'h04;

    localparam logic [1:0] DCF_CODE_HH = 2'h3;
    localparam logic [1:0] DCF_CODE_HL = 2'h2;
    localparam logic [1:0] DCF_CODE_LH = 2'h1;

    // port control pins, sampled on the rising edge of the port clock
    typedef struct packed {
        logic select_n;
        logic dir;
        logic xfer_gate;
        logic mail_sel;
    } dcf_port_ctl_t;

    // write-side start-up: the full flag rises on the second edge
    typedef enum logic [1:0] {
        DCF_INIT0 = 2'b00,
        DCF_INIT1 = 2'b01,
        DCF_RUN   = 2'b11
    } dcf_init_t;

endpackage

// [design/dcf_fifo_flags.sv]
// 64 x 36 dual-clock fifo with full/almost-full on the port-a clock,
// empty/almost-empty on the port-b clock, and one mailbox each way.
// assumes port control pins meet setup/hold to their own port clock.
`timescale 1ns/10ps

module dcf_fifo_flags
    import dcf_pkg::*;
(
    input  wire logic                 write_port_clock,
    input  wire logic                 read_port_clock,
    input  wire logic                 rstn,
    input  wire logic                 threshold_code_lo,
    input  wire logic                 threshold_code_hi,
    input  wire dcf_port_ctl_t        port_a_ctl,
    input  wire logic [DCF_WIDTH-1:0] port_a_din,
    output logic      [DCF_WIDTH-1:0] port_a_dout,
    output logic                      port_a_oe,
    input  wire dcf_port_ctl_t        port_b_ctl,
    input  wire logic [DCF_WIDTH-1:0] port_b_din,
    output logic      [DCF_WIDTH-1:0] port_b_dout,
    output logic                      port_b_oe,
    output logic                      write_side_full_n,
    output logic                      near_full_n,
    output logic                      read_side_empty_n,
    output logic                      near_empty_n,
    output logic                      mail_ab_present_n,
    output logic                      mail_ba_present_n
);

    function automatic logic xfer(input dcf_port_ctl_t c,
                                  input logic         wr);
        return !c.select_n && c.xfer_gate && (c.dir == wr);
    endfunction

    function automatic logic [DCF_PW-1:0] b2g(input logic [DCF_PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [DCF_PW-1:0] g2b(input logic [DCF_PW-1:0] g);
        logic [DCF_PW-1:0] b;
        b = g;
        for (int i = 1; i < DCF_PW; i++)
        begin
            b = b ^ (g >> i);
        end
        return b;
    endfunction

    function automatic logic [DCF_OW-1:0] ofs_decode(input logic [1:0] c);
        unique case (c)
            DCF_CODE_HH: return DCF_OFS_HH;
            DCF_CODE_HL: return DCF_OFS_HL;
            DCF_CODE_LH: return DCF_OFS_LH;
            default:     return DCF_OFS_LL;
        endcase
    endfunction

    logic [DCF_WIDTH-1:0] mem [DCF_DEPTH];

    // write (port-a) domain state
    dcf_init_t            init_r;
    logic [1:0]           thr_s1_r;
    logic [1:0]           thr_s2_r;
    logic                 ofs_loaded_r;
    logic [DCF_OW-1:0]    ofs_a_r;
    logic [DCF_PW-1:0]    wr_bin_r;
    logic [DCF_PW-1:0]    wr_gray_r;
    logic [DCF_PW-1:0]    rg_s1_r;
    logic [DCF_PW-1:0]    rg_s2_r;
    logic [DCF_PW-1:0]    count_a;
    logic [DCF_WIDTH-1:0] mail_ab_r;
    logic                 ab_wt_r;
    logic                 abr_s1_r;
    logic                 abr_s2_r;
    logic                 ba_rt_r;
    logic                 baw_s1_r;
    logic                 baw_s2_r;
    logic                 a_wr_fifo;
    logic                 a_wr_mail;
    logic                 a_rd_mail;

    // read (port-b) domain state
    logic [DCF_OW-1:0]    ofs_s1_r;
    logic [DCF_OW-1:0]    ofs_b_r;
    logic [DCF_PW-1:0]    rd_bin_r;
    logic [DCF_PW-1:0]    rd_gray_r;
    logic [DCF_PW-1:0]    wg_s1_r;
    logic [DCF_PW-1:0]    wg_s2_r;
    logic [DCF_PW-1:0]    count_b;
    logic [DCF_WIDTH-1:0] fifo_out_r;
    logic [DCF_WIDTH-1:0] mail_ba_r;
    logic                 ba_wt_r;
    logic                 bar_s1_r;
    logic                 bar_s2_r;
    logic                 ab_rt_r;
    logic                 abw_s1_r;
    logic                 abw_s2_r;
    logic                 ab_avail_b;
    logic                 b_rd_fifo;
    logic                 b_rd_mail;
    logic                 b_wr_mail;

    // ---------------- port-a (write) clock domain ----------------

    always_ff @(posedge write_port_clock or negedge rstn)
    begin
        if (!rstn)
            init_r <= DCF_INIT0;
        else
        begin
            unique case (init_r)
                DCF_INIT0: init_r <= DCF_INIT1;
                DCF_INIT1: init_r <= DCF_RUN;
                DCF_RUN:   init_r <= DCF_RUN;
                default:   init_r <= DCF_INIT0;
            endcase
        end
    end

    // straps are caught after release, never by the async reset itself
    always_ff @(posedge write_port_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            thr_s1_r     <= 2'h0;
            thr_s2_r     <= 2'h0;
            ofs_loaded_r <= 1'b0;
            ofs_a_r      <= DCF_OFS_RST;
        end
        else
        begin
            thr_s1_r <= {threshold_code_hi, threshold_code_lo};
            thr_s2_r <= thr_s1_r;
            if (init_r == DCF_RUN && !ofs_loaded_r)
            begin
                ofs_a_r      <= ofs_decode(thr_s2_r);
                ofs_loaded_r <= 1'b1;
            end
        end
    end

    assign a_wr_fifo = xfer(port_a_ctl, 1'b1) && !port_a_ctl.mail_sel
                       && write_side_full_n;
    assign a_wr_mail = xfer(port_a_ctl, 1'b1) && port_a_ctl.mail_sel
                       && mail_ab_present_n;
    assign a_rd_mail = xfer(port_a_ctl, 1'b0) && port_a_ctl.mail_sel;

    always_ff @(posedge write_port_clock)
    begin
        if (a_wr_fifo)
            mem[wr_bin_r[DCF_AW-1:0]] <= port_a_din;
    end

    always_ff @(posedge write_port_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_bin_r  <= '0;
            wr_gray_r <= '0;
        end
        else if (a_wr_fifo)
        begin
            wr_bin_r  <= wr_bin_r + 7'h01;
            wr_gray_r <= b2g(wr_bin_r + 7'h01);
        end
    end

    // two-stage sync of the read pointer sets the release latency;
    // a read edge too close to ours simply lands one cycle later
    always_ff @(posedge write_port_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rg_s1_r <= '0;
            rg_s2_r <= '0;
        end
        else
        begin
            rg_s1_r <= rd_gray_r;
            rg_s2_r <= rg_s1_r;
        end
    end

    assign count_a = wr_bin_r - g2b(rg_s2_r);
    assign write_side_full_n = (init_r == DCF_RUN)
                               && (count_a != DCF_FULL_COUNT);
    assign near_full_n = count_a
                         < (DCF_FULL_COUNT - {2'h0, ofs_a_r});

    // a-to-b mailbox: written here, flag cleared by a toggle from b
    always_ff @(posedge write_port_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            mail_ab_r <= '0;
            ab_wt_r   <= 1'b0;
            abr_s1_r  <= 1'b0;
            abr_s2_r  <= 1'b0;
        end
        else
        begin
            abr_s1_r <= ab_rt_r;
            abr_s2_r <= abr_s1_r;
            if (a_wr_mail)
            begin
                mail_ab_r <= port_a_din;
                ab_wt_r   <= ~ab_wt_r;
            end
        end
    end

    assign mail_ab_present_n = (ab_wt_r == abr_s2_r);

    // b-to-a mailbox read side: acknowledge only mail actually seen
    always_ff @(posedge write_port_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ba_rt_r  <= 1'b0;
            baw_s1_r <= 1'b0;
            baw_s2_r <= 1'b0;
        end
        else
        begin
            baw_s1_r <= ba_wt_r;
            baw_s2_r <= baw_s1_r;
            if (a_rd_mail && (baw_s2_r != ba_rt_r))
                ba_rt_r <= ~ba_rt_r;
        end
    end

    assign port_a_oe   = !port_a_ctl.select_n && !port_a_ctl.dir;
    assign port_a_dout = mail_ba_r;

    // ---------------- port-b (read) clock domain ----------------

    // offset changes only once after reset, so a plain resync is safe
    always_ff @(posedge read_port_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ofs_s1_r <= DCF_OFS_RST;
            ofs_b_r  <= DCF_OFS_RST;
        end
        else
        begin
            ofs_s1_r <= ofs_a_r;
            ofs_b_r  <= ofs_s1_r;
        end
    end

    always_ff @(posedge read_port_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            wg_s1_r <= '0;
            wg_s2_r <= '0;
        end
        else
        begin
            wg_s1_r <= wr_gray_r;
            wg_s2_r <= wg_s1_r;
        end
    end

    assign count_b           = g2b(wg_s2_r) - rd_bin_r;
    assign read_side_empty_n = (count_b != 7'h00);
    assign near_empty_n      = count_b > {2'h0, ofs_b_r};

    assign b_rd_fifo = xfer(port_b_ctl, 1'b0) && !port_b_ctl.mail_sel
                       && read_side_empty_n;
    assign b_rd_mail = xfer(port_b_ctl, 1'b0) && port_b_ctl.mail_sel;
    assign b_wr_mail = xfer(port_b_ctl, 1'b1) && port_b_ctl.mail_sel
                       && mail_ba_present_n;

    always_ff @(posedge read_port_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_bin_r   <= '0;
            rd_gray_r  <= '0;
            fifo_out_r <= '0;
        end
        else if (b_rd_fifo)
        begin
            fifo_out_r <= mem[rd_bin_r[DCF_AW-1:0]];
            rd_bin_r   <= rd_bin_r + 7'h01;
            rd_gray_r  <= b2g(rd_bin_r + 7'h01);
        end
    end

    assign ab_avail_b = (abw_s2_r != ab_rt_r);

    always_ff @(posedge read_port_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ab_rt_r  <= 1'b0;
            abw_s1_r <= 1'b0;
            abw_s2_r <= 1'b0;
        end
        else
        begin
            abw_s1_r <= ab_wt_r;
            abw_s2_r <= abw_s1_r;
            if (b_rd_mail && ab_avail_b)
                ab_rt_r <= ~ab_rt_r;
        end
    end

    always_ff @(posedge read_port_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            mail_ba_r <= '0;
            ba_wt_r   <= 1'b0;
            bar_s1_r  <= 1'b0;
            bar_s2_r  <= 1'b0;
        end
        else
        begin
            bar_s1_r <= ba_rt_r;
            bar_s2_r <= bar_s1_r;
            if (b_wr_mail)
            begin
                mail_ba_r <= port_b_din;
                ba_wt_r   <= ~ba_wt_r;
            end
        end
    end

    assign mail_ba_present_n = (ba_wt_r == bar_s2_r);

    assign port_b_oe   = !port_b_ctl.select_n && !port_b_ctl.dir;
    assign port_b_dout = port_b_ctl.mail_sel ? mail_ab_r : fifo_out_r;

    // ---------------- checks ----------------

    sequence s_init_tail;
        (init_r == DCF_INIT1) ##1 (init_r == DCF_RUN);
    endsequence

    a_init_full_rise: assert property (@(posedge write_port_clock)
        disable iff (!rstn)
        (init_r == DCF_INIT0) |=> s_init_tail ##0 write_side_full_n == 1'b1
                                  || count_a == DCF_FULL_COUNT)
        else $error("full flag did not rise on second edge after reset");

    a_full_drops_wr: assert property (@(posedge write_port_clock)
        disable iff (!rstn)
        (!write_side_full_n && xfer(port_a_ctl, 1'b1)) |=> $stable(wr_bin_r))
        else $error("write accepted while full");

    a_wptr_step_one: assert property (@(posedge write_port_clock)
        disable iff (!rstn)
        a_wr_fifo |=> wr_bin_r == $past(wr_bin_r) + 7'h01)
        else $error("write pointer did not step by one");

    a_full_from_sync: assert property (@(posedge write_port_clock)
        disable iff (!rstn)
        ($rose(write_side_full_n) && $past(init_r) == DCF_RUN)
            |-> $changed(rg_s2_r))
        else $error("full released without synced read");

    a_near_full_cov: assert property (@(posedge write_port_clock)
        disable iff (!rstn)
        (init_r == DCF_RUN && !write_side_full_n) |-> !near_full_n)
        else $error("almost-full high while full");

    a_near_empty_sync: assert property (@(posedge read_port_clock)
        disable iff (!rstn)
        $rose(near_empty_n) |-> ($changed(wg_s2_r) || $changed(ofs_b_r)))
        else $error("almost-empty rose without synced write");

    a_near_empty_lvl: assert property (@(posedge read_port_clock)
        disable iff (!rstn)
        near_empty_n |-> read_side_empty_n)
        else $error("almost-empty high while empty");

    a_mail_ab_flag: assert property (@(posedge write_port_clock)
        disable iff (!rstn)
        a_wr_mail |=> !mail_ab_present_n ##1 $stable(mail_ab_r))
        else $error("mailbox flag not lowered or contents overwritten");

    a_mail_ab_hold: assert property (@(posedge write_port_clock)
        disable iff (!rstn)
        !a_wr_mail |=> $stable(mail_ab_r))
        else $error("mailbox changed without accepted write");

    a_mail_ab_ack: assert property (@(posedge read_port_clock)
        disable iff (!rstn)
        (b_rd_mail && ab_avail_b) |=> !ab_avail_b [*2])
        else $error("mailbox read did not acknowledge");

endmodule

// [tb/dcf_port_agent.sv]
// partner model: a synchronous bus master on one port of the fifo
// assumes one caller at a time, running from the testbench thread
`timescale 1ns/10ps
module dcf_port_agent
    import dcf_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic [DCF_WIDTH-1:0] dout,
    input  wire logic                 oe,
    output dcf_port_ctl_t             ctl,
    output logic      [DCF_WIDTH-1:0] din
);
    // output enable as it stood while the last request was sampled
    logic oe_seen = 1'b0;

    initial
    begin
        ctl = '{1'b1, 1'b0, 1'b0, 1'b0};
        din = '0;
    end

    // request held over exactly one sampling edge, then withdrawn
    task automatic xfer(input dcf_port_ctl_t               c,
                        input logic [DCF_WIDTH-1:0] d,
                        output logic [DCF_WIDTH-1:0] q);
        @(posedge clock);
        ctl <= c;
        din <= d;
        @(posedge clock);
        oe_seen = oe;
        // mail_sel kept so the read mux still shows what was read
        ctl <= '{1'b1, c.dir, 1'b0, c.mail_sel};
        // released bus shows the inverse, never a stale copy
        din <= ~d;
        #1;
        q = dout;
    endtask
endmodule

// [tb/tb_dual_clock_fifo_flags_mailbox.sv]
// self-checking bench: fill and drain per threshold code, mailboxes
// assumes the port agents hold each request for one sampling edge
`timescale 1ns/10ps
`define CHK(g, e) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("Error t=%0t got %h exp %h", $time, (g), (e)); \
        end \
    end
module tb_dual_clock_fifo_flags_mailbox
    import dcf_pkg::*;
;
    localparam dcf_port_ctl_t WR_F = '{1'b0, 1'b1, 1'b1, 1'b0};
    localparam dcf_port_ctl_t RD_F = '{1'b0, 1'b0, 1'b1, 1'b0};
    localparam dcf_port_ctl_t WR_M = '{1'b0, 1'b1, 1'b1, 1'b1};
    localparam dcf_port_ctl_t RD_M = '{1'b0, 1'b0, 1'b1, 1'b1};
    localparam dcf_port_ctl_t PK_M = '{1'b0, 1'b0, 1'b0, 1'b1};
    localparam dcf_port_ctl_t NO_G = '{1'b0, 1'b1, 1'b0, 1'b0};
    localparam dcf_port_ctl_t NO_S = '{1'b1, 1'b1, 1'b1, 1'b0};

    logic                 clk_a    = 1'b0;
    logic                 clk_b    = 1'b0;
    logic                 rstn     = 1'b0;
    logic                 code_lo  = 1'b0;
    logic                 code_hi  = 1'b0;
    dcf_port_ctl_t        ctl_a;
    dcf_port_ctl_t        ctl_b;
    logic [DCF_WIDTH-1:0] din_a;
    logic [DCF_WIDTH-1:0] din_b;
    logic [DCF_WIDTH-1:0] dout_a;
    logic [DCF_WIDTH-1:0] dout_b;
    logic [DCF_WIDTH-1:0] q;
    logic                 oe_a;
    logic                 oe_b;
    logic                 full_n;
    logic                 nfull_n;
    logic                 empty_n;
    logic                 nempty_n;
    logic                 mab_n;
    logic                 mba_n;
    int                   n_errors = 0;
    int                   samples_checked = 0;
    int                   ofs;

    // rising edges of the two clocks never coincide
    always #4 clk_a = ~clk_a;
    always #5 clk_b = ~clk_b;

    dcf_port_agent u_pa (.clock(clk_a), .dout(dout_a), .oe(oe_a),
                         .ctl(ctl_a), .din(din_a));
    dcf_port_agent u_pb (.clock(clk_b), .dout(dout_b), .oe(oe_b),
                         .ctl(ctl_b), .din(din_b));

    dcf_fifo_flags uut (
        .write_port_clock  (clk_a),
        .read_port_clock   (clk_b),
        .rstn              (rstn),
        .threshold_code_lo (code_lo),
        .threshold_code_hi (code_hi),
        .port_a_ctl        (ctl_a),
        .port_a_din        (din_a),
        .port_a_dout       (dout_a),
        .port_a_oe         (oe_a),
        .port_b_ctl        (ctl_b),
        .port_b_din        (din_b),
        .port_b_dout       (dout_b),
        .port_b_oe         (oe_b),
        .write_side_full_n (full_n),
        .near_full_n       (nfull_n),
        .read_side_empty_n (empty_n),
        .near_empty_n      (nempty_n),
        .mail_ab_present_n (mab_n),
        .mail_ba_present_n (mba_n)
    );

    task automatic final_report;
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // covers the worst flag path: third edge of either clock
    task automatic settle;
        repeat (4) @(posedge clk_b);
    endtask

    task automatic do_reset(input logic hi, input logic lo);
        @(posedge clk_a);
        rstn    <= 1'b0;
        code_hi <= hi;
        code_lo <= lo;
        repeat (10) @(posedge clk_a);
        `CHK({full_n, empty_n, nempty_n, nfull_n, mab_n, mba_n},
             6'h07)
        rstn <= 1'b1;
        @(posedge clk_a);
        #1;
        `CHK(full_n, 1'b0)
        @(posedge clk_a);
        #1;
        `CHK(full_n, 1'b1)
        // strap sync into both domains before traffic
        repeat (4) @(posedge clk_a);
        settle;
    endtask

    initial
    begin
        for (int c = 0; c < 4; c++)
        begin
            do_reset(c[1], c[0]);
            ofs = 4 + 4 * c;
            for (int i = 0; i < 64; i++)
            begin
                u_pa.xfer(WR_F, 36'h9_0000_0000 + 36'(i), q);
                if (i == ofs - 1 || i == ofs || i == 62 - ofs ||
                    i == 63 - ofs)
                begin
                    settle;
                    `CHK(nempty_n, logic'(i >= ofs))
                    `CHK(nfull_n, logic'(i < 63 - ofs))
                end
            end
            settle;
            `CHK(full_n, 1'b0)
            u_pa.xfer(WR_F, 36'h0_dead_0001, q);
            for (int j = 0; j < 64; j++)
            begin
                u_pb.xfer(RD_F, '0, q);
                `CHK(q, 36'h9_0000_0000 + 36'(j))
                if (j == 0 || j == ofs - 1 || j == ofs)
                begin
                    settle;
                    `CHK(full_n, 1'b1)
                    `CHK(nfull_n, logic'(j >= ofs))
                end
            end
            // writes missing the gate or the select are not taken
            u_pa.xfer(NO_G, 36'h0_0000_0011, q);
            u_pa.xfer(NO_S, 36'h0_0000_0022, q);
            settle;
            `CHK(empty_n, 1'b0)
        end
        u_pa.xfer(WR_M, 36'h1_2345_6789, q);
        `CHK(mab_n, 1'b0)
        `CHK(u_pa.oe_seen, 1'b0)
        u_pa.xfer(WR_M, 36'h0_0000_0bad, q);
        settle;
        u_pb.xfer(PK_M, '0, q);
        `CHK(q, 36'h1_2345_6789)
        `CHK(mab_n, 1'b0)
        `CHK(u_pb.oe_seen, 1'b1)
        `CHK(oe_b, 1'b0)
        u_pb.xfer(RD_M, '0, q);
        settle;
        `CHK(mab_n, 1'b1)
        u_pb.xfer(PK_M, '0, q);
        `CHK(q, 36'h1_2345_6789)
        u_pb.xfer(WR_M, 36'h8_7654_3210, q);
        `CHK(mba_n, 1'b0)
        `CHK(u_pb.oe_seen, 1'b0)
        u_pb.xfer(WR_M, 36'h0_0000_0bad, q);
        settle;
        u_pa.xfer(RD_F, '0, q);
        `CHK(q, 36'h8_7654_3210)
        `CHK(mba_n, 1'b0)
        `CHK(u_pa.oe_seen, 1'b1)
        `CHK(oe_a, 1'b0)
        u_pa.xfer(RD_M, '0, q);
        settle;
        `CHK(mba_n, 1'b1)
        u_pa.xfer(PK_M, '0, q);
        `CHK(q, 36'h8_7654_3210)
        final_report;
    end

    initial
    begin
        repeat (100000) @(posedge clk_a);
        n_errors++;
        final_report;
    end
endmodule
